// >>> hw/bsrm_pkg.sv
// constants, offsets and reset values for the bank 1 special register map
package bsrm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (bank 1 addresses; shared ones mirror at bit 7 clear)
  localparam logic [7:0] OFS_INDIRECT_ACCESS_PORT = 8'h80;
  localparam logic [7:0] OFS_PRESCALER_EDGE_CONFIG = 8'h81;
  localparam logic [7:0] OFS_PC_LOW_BYTE = 8'h82;
  localparam logic [7:0] OFS_CORE_FLAGS = 8'h83;
  localparam logic [7:0] OFS_INDIRECT_POINTER = 8'h84;
  localparam logic [7:0] OFS_DIR_PORT_A = 8'h85;
  localparam logic [7:0] OFS_DIR_PORT_B = 8'h86;
  localparam logic [7:0] OFS_DIR_PORT_C = 8'h87;
  localparam logic [7:0] OFS_DIR_PORT_D = 8'h88;
  localparam logic [7:0] OFS_DIR_PORT_E_PARALLEL_STATUS = 8'h89;
  localparam logic [7:0] OFS_PC_HIGH_LATCH = 8'h8a;
  localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h8b;
  localparam logic [7:0] OFS_PERIPH_INT_ENABLE_1 = 8'h8c;
  localparam logic [7:0] OFS_PERIPH_INT_ENABLE_2 = 8'h8d;
  localparam logic [7:0] OFS_POWER_RESET_FLAGS = 8'h8e;
  localparam logic [7:0] OFS_TIMER2_PERIOD = 8'h92;
  localparam logic [7:0] OFS_SYNC_SERIAL_ADDRESS = 8'h93;
  localparam logic [7:0] OFS_SYNC_SERIAL_STATUS = 8'h94;
  localparam logic [7:0] OFS_UART_TX_CONTROL_STATUS = 8'h98;
  localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h99;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int SF_IND_BANK = 7;
  localparam int SF_TO = 4;
  localparam int SF_PD = 3;
  localparam int TE_IBOV = 5;
  localparam int TE_PSPMODE = 4;
  localparam int PF_POR = 1;
  localparam int PF_BROWNOUT = 0;
  localparam logic [7:0] CORE_FLAGS_WR_MASK = 8'he7;
  localparam logic [7:0] TX_CTRL_WR_MASK = 8'hf5;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_PRESCALER_EDGE_CONFIG = 8'hff;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic [7:0] RST_CORE_FLAGS_PON = 8'h18;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  localparam logic [5:0] RST_DIR_PORT_A = 6'h3f;
  localparam logic [7:0] RST_DIR_PORT_BCD = 8'hff;
  localparam logic [2:0] RST_DIR_PORT_E = 3'h7;
  localparam logic [4:0] RST_PC_HIGH_LATCH = 5'h00;
  localparam logic [7:0] RST_TIMER2_PERIOD = 8'hff;
  localparam logic [7:0] RST_TX_CTRL = 8'h00;
  localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // general purpose data memory behind the indirect port
  localparam int RAM_AW = 9;
  localparam int RAM_DEPTH = 512;
  localparam logic [6:0] GPR_BASE = 7'h20;

  typedef enum logic [1:0] {
    BSRM_RST_PIN = 2'h0,
    BSRM_RST_WDT = 2'h1,
    BSRM_RST_PON = 2'h2,
    BSRM_RST_BROWNOUT = 2'h3
  } bsrm_rst_cause_t;

endpackage : bsrm_pkg

// >>> hw/bsrm_gpr_ram.sv
// general purpose data memory reached through the indirect port
`timescale 1ns/1ps
module bsrm_gpr_ram (
  // clock
  input wire logic clock,
  // write side
  input wire logic we,
  input wire logic [bsrm_pkg::RAM_AW-1:0] addr,
  input wire logic [7:0] wdata,
  // read side, combinational
  output logic [7:0] rdata
);
  import bsrm_pkg::*;

  logic [7:0] mem [0:RAM_DEPTH-1];

  // no reset: contents are undefined until written
  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];

endmodule : bsrm_gpr_ram

// >>> hw/bsrm_bank1_map.sv
// bank 1 special function registers with indirect port and program counter
// How it works
// RQ1: unimplemented locations and bits read zero; writes there do nothing.
// RQ2: core-shared registers answer at the same storage from either bank.
// RQ3: upper program counter bits only load from the five-bit high latch.
// RQ4: pin and watchdog resets use other-reset values; power-on and brown-out use power-up.
// RQ5: indirect port has no storage; access goes to the pointer's address.
// RQ6: software keeps the reserved brown-out flag at one where reserved.
// RQ7: software keeps reserved bank select bits cleared where reserved.
// RQ8: software keeps reserved bit six of enable and flag registers cleared.
// RQ9: baud divisor clears to zero on non-power-up resets too.
// RQ10: every reset loads table values; unchanged fields hold, unknown ones kept (power-up zeroes pointer, interrupt control and low core flags).
`timescale 1ns/1ps
module bsrm_bank1_map (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  input wire bsrm_pkg::bsrm_rst_cause_t RST_CAUSE,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WSTB,
  input wire logic RSTB,
  output logic [7:0] RDATA,
  // program counter
  input wire logic PC_STEP,
  output logic [12:0] PC_VALUE,
  output logic [2:0] BANK_SEL,
  // peripheral status in
  input wire logic PSP_IN_FULL,
  input wire logic PSP_OUT_FULL,
  input wire logic PSP_OVERFLOW,
  input wire logic [5:0] SSP_STATUS,
  input wire logic TX_SHIFT_EMPTY,
  // configuration out
  output logic [7:0] OPTION_CFG,
  output logic [5:0] TRIS_A,
  output logic [7:0] TRIS_B,
  output logic [7:0] TRIS_C,
  output logic [7:0] TRIS_D,
  output logic [2:0] TRIS_E,
  output logic PSP_MODE,
  output logic [7:0] INT_CTRL,
  output logic [7:0] PERIPH_IRQ_EN_1,
  output logic PERIPH_IRQ_EN_2,
  output logic [7:0] TMR2_PERIOD,
  output logic [7:0] SSP_ADDR,
  output logic [7:0] TX_CTRL,
  output logic [7:0] BAUD_DIV
);
  import bsrm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic [7:0] canon(input logic [7:0] a);
    canon = {1'b1, a[6:0]};
  endfunction : canon

  function automatic logic map_hit(input logic [7:0] a);
    map_hit = 1'b0;
    if (a[6:5] == 2'b00) begin
      case (canon(a))
        OFS_INDIRECT_ACCESS_PORT, OFS_PC_LOW_BYTE, OFS_CORE_FLAGS, OFS_INDIRECT_POINTER,
        OFS_PC_HIGH_LATCH, OFS_INTERRUPT_CONTROL: map_hit = 1'b1; // [RQ2]
        OFS_PRESCALER_EDGE_CONFIG, OFS_DIR_PORT_A, OFS_DIR_PORT_B, OFS_DIR_PORT_C,
        OFS_DIR_PORT_D, OFS_DIR_PORT_E_PARALLEL_STATUS, OFS_PERIPH_INT_ENABLE_1,
        OFS_PERIPH_INT_ENABLE_2, OFS_POWER_RESET_FLAGS, OFS_TIMER2_PERIOD,
        OFS_SYNC_SERIAL_ADDRESS, OFS_SYNC_SERIAL_STATUS, OFS_UART_TX_CONTROL_STATUS,
        OFS_BAUD_DIVISOR: map_hit = a[7];
        default: map_hit = 1'b0; // [RQ1]
      endcase
    end
  endfunction : map_hit

  logic [7:0] option_r, option_nxt;
  logic [12:0] pc_r, pc_nxt;
  logic [7:0] status_r, status_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic [5:0] dira_r, dira_nxt;
  logic [7:0] dirb_r, dirb_nxt;
  logic [7:0] dirc_r, dirc_nxt;
  logic [7:0] dird_r, dird_nxt;
  logic [2:0] dire_r, dire_nxt;
  logic pspmode_r, pspmode_nxt;
  logic ibov_r, ibov_nxt;
  logic [4:0] latch_r, latch_nxt;
  logic [7:0] intctl_r, intctl_nxt;
  logic [7:0] ie1_r, ie1_nxt;
  logic ie2_r, ie2_nxt;
  logic [1:0] pwr_r, pwr_nxt;
  logic [7:0] period_r, period_nxt;
  logic [7:0] ssp_adr_r, ssp_adr_nxt;
  logic [7:0] txctl_r, txctl_nxt;
  logic [7:0] baud_r, baud_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  logic is_ind;
  logic [7:0] ea;
  logic ea_reg;
  logic ea_ram;
  logic ram_we;
  logic [7:0] ram_rdata;
  logic pon;

  // the indirect port redirects to the pointer; pointing it at itself reads zero
  assign is_ind = map_hit(ADDR) && (canon(ADDR) == OFS_INDIRECT_ACCESS_PORT); // [RQ5]
  assign ea = is_ind ? ptr_r : ADDR; // [RQ5]
  assign ea_reg = map_hit(ea) && (canon(ea) != OFS_INDIRECT_ACCESS_PORT); // [RQ5]
  assign ea_ram = is_ind && !map_hit(ptr_r) && (ptr_r[6:0] >= GPR_BASE); // [RQ5]
  assign ram_we = WSTB && ea_ram && !SRST; // [RQ5]
  assign pon = (RST_CAUSE == BSRM_RST_PON) || (RST_CAUSE == BSRM_RST_BROWNOUT); // [RQ4]

  bsrm_gpr_ram u_ram (
    .clock(CLOCK),
    .we(ram_we),
    .addr({status_r[SF_IND_BANK], ptr_r}),
    .wdata(WDATA),
    .rdata(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    option_nxt = option_r;
    pc_nxt = pc_r;
    status_nxt = status_r;
    ptr_nxt = ptr_r;
    dira_nxt = dira_r;
    dirb_nxt = dirb_r;
    dirc_nxt = dirc_r;
    dird_nxt = dird_r;
    dire_nxt = dire_r;
    pspmode_nxt = pspmode_r;
    ibov_nxt = ibov_r;
    latch_nxt = latch_r;
    intctl_nxt = intctl_r;
    ie1_nxt = ie1_r;
    ie2_nxt = ie2_r;
    pwr_nxt = pwr_r;
    period_nxt = period_r;
    ssp_adr_nxt = ssp_adr_r;
    txctl_nxt = txctl_r;
    baud_nxt = baud_r;
    rdata_nxt = RST_ZERO8;
    if (SRST) begin
      option_nxt = RST_PRESCALER_EDGE_CONFIG; // [RQ10]
      pc_nxt = RST_PC; // [RQ10]
      dira_nxt = RST_DIR_PORT_A; // [RQ10]
      dirb_nxt = RST_DIR_PORT_BCD; // [RQ10]
      dirc_nxt = RST_DIR_PORT_BCD; // [RQ10]
      dird_nxt = RST_DIR_PORT_BCD; // [RQ10]
      dire_nxt = RST_DIR_PORT_E; // [RQ10]
      pspmode_nxt = 1'b0;
      ibov_nxt = 1'b0;
      latch_nxt = RST_PC_HIGH_LATCH; // [RQ10]
      ie1_nxt = RST_ZERO8;
      ie2_nxt = 1'b0;
      period_nxt = RST_TIMER2_PERIOD; // [RQ10]
      ssp_adr_nxt = RST_ZERO8;
      txctl_nxt = RST_TX_CTRL; // [RQ10]
      baud_nxt = RST_BAUD_DIVISOR; // [RQ9]
      if (pon) begin
        // unknown fields are given zero so nothing starts as an x
        status_nxt = RST_CORE_FLAGS_PON; // [RQ4]
        ptr_nxt = RST_ZERO8; // [RQ4]
        intctl_nxt = RST_ZERO8; // [RQ4]
        pwr_nxt[PF_POR] = (RST_CAUSE != BSRM_RST_PON); // [RQ4]
        pwr_nxt[PF_BROWNOUT] = (RST_CAUSE != BSRM_RST_BROWNOUT); // [RQ4]
      end else begin
        // bank bits clear, timeout marks a watchdog reset, low flags hold
        status_nxt = {3'b000, RST_CAUSE != BSRM_RST_WDT, 1'b1, status_r[2:0]}; // [RQ4]
        intctl_nxt = {7'b000_0000, intctl_r[0]}; // [RQ10]
      end
    end else begin
      if (PC_STEP) begin
        pc_nxt = pc_r + 13'h0001;
      end
      if (WSTB && ea_reg) begin
        case (canon(ea))
          OFS_PRESCALER_EDGE_CONFIG: option_nxt = WDATA;
          OFS_PC_LOW_BYTE: pc_nxt = {latch_r, WDATA}; // [RQ3]
          OFS_CORE_FLAGS: status_nxt = (status_r & ~CORE_FLAGS_WR_MASK) | (WDATA & CORE_FLAGS_WR_MASK);
          OFS_INDIRECT_POINTER: ptr_nxt = WDATA;
          OFS_DIR_PORT_A: dira_nxt = WDATA[5:0]; // [RQ1]
          OFS_DIR_PORT_B: dirb_nxt = WDATA;
          OFS_DIR_PORT_C: dirc_nxt = WDATA;
          OFS_DIR_PORT_D: dird_nxt = WDATA;
          OFS_DIR_PORT_E_PARALLEL_STATUS: begin
            dire_nxt = WDATA[2:0];
            pspmode_nxt = WDATA[TE_PSPMODE];
            ibov_nxt = WDATA[TE_IBOV];
          end
          OFS_PC_HIGH_LATCH: latch_nxt = WDATA[4:0]; // [RQ1]
          OFS_INTERRUPT_CONTROL: intctl_nxt = WDATA;
          OFS_PERIPH_INT_ENABLE_1: ie1_nxt = WDATA;
          OFS_PERIPH_INT_ENABLE_2: ie2_nxt = WDATA[0]; // [RQ1]
          OFS_POWER_RESET_FLAGS: pwr_nxt = WDATA[1:0];
          OFS_TIMER2_PERIOD: period_nxt = WDATA;
          OFS_SYNC_SERIAL_ADDRESS: ssp_adr_nxt = WDATA;
          OFS_UART_TX_CONTROL_STATUS: txctl_nxt = WDATA & TX_CTRL_WR_MASK;
          OFS_BAUD_DIVISOR: baud_nxt = WDATA;
          default: ;
        endcase
      end
      // a hardware overflow beats a clearing write in the same cycle
      if (PSP_OVERFLOW) begin
        ibov_nxt = 1'b1;
      end
      if (RSTB) begin
        if (ea_reg) begin
          case (canon(ea))
            OFS_PRESCALER_EDGE_CONFIG: rdata_nxt = option_r;
            OFS_PC_LOW_BYTE: rdata_nxt = pc_r[7:0]; // [RQ3]
            OFS_CORE_FLAGS: rdata_nxt = status_r;
            OFS_INDIRECT_POINTER: rdata_nxt = ptr_r;
            OFS_DIR_PORT_A: rdata_nxt = {2'b00, dira_r}; // [RQ1]
            OFS_DIR_PORT_B: rdata_nxt = dirb_r;
            OFS_DIR_PORT_C: rdata_nxt = dirc_r;
            OFS_DIR_PORT_D: rdata_nxt = dird_r;
            OFS_DIR_PORT_E_PARALLEL_STATUS:
              rdata_nxt = {PSP_IN_FULL, PSP_OUT_FULL, ibov_r, pspmode_r, 1'b0, dire_r}; // [RQ1]
            OFS_PC_HIGH_LATCH: rdata_nxt = {3'b000, latch_r}; // [RQ1]
            OFS_INTERRUPT_CONTROL: rdata_nxt = intctl_r;
            OFS_PERIPH_INT_ENABLE_1: rdata_nxt = ie1_r;
            OFS_PERIPH_INT_ENABLE_2: rdata_nxt = {7'b000_0000, ie2_r}; // [RQ1]
            OFS_POWER_RESET_FLAGS: rdata_nxt = {6'b00_0000, pwr_r}; // [RQ1]
            OFS_TIMER2_PERIOD: rdata_nxt = period_r;
            OFS_SYNC_SERIAL_ADDRESS: rdata_nxt = ssp_adr_r;
            OFS_SYNC_SERIAL_STATUS: rdata_nxt = {2'b00, SSP_STATUS}; // [RQ1]
            OFS_UART_TX_CONTROL_STATUS: rdata_nxt = {txctl_r[7:2], TX_SHIFT_EMPTY, txctl_r[0]};
            OFS_BAUD_DIVISOR: rdata_nxt = baud_r;
            default: rdata_nxt = RST_ZERO8;
          endcase
        end else if (ea_ram) begin
          rdata_nxt = ram_rdata; // [RQ5]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CLOCK) begin
    option_r <= option_nxt;
    pc_r <= pc_nxt;
    status_r <= status_nxt;
    ptr_r <= ptr_nxt;
    dira_r <= dira_nxt;
    dirb_r <= dirb_nxt;
    dirc_r <= dirc_nxt;
    dird_r <= dird_nxt;
    dire_r <= dire_nxt;
    pspmode_r <= pspmode_nxt;
    ibov_r <= ibov_nxt;
    latch_r <= latch_nxt;
    intctl_r <= intctl_nxt;
    ie1_r <= ie1_nxt;
    ie2_r <= ie2_nxt;
    pwr_r <= pwr_nxt;
    period_r <= period_nxt;
    ssp_adr_r <= ssp_adr_nxt;
    txctl_r <= txctl_nxt;
    baud_r <= baud_nxt;
    rdata_r <= rdata_nxt;
  end

  assign RDATA = rdata_r;
  assign PC_VALUE = pc_r;
  assign BANK_SEL = status_r[7:5];
  assign OPTION_CFG = option_r;
  assign TRIS_A = dira_r;
  assign TRIS_B = dirb_r;
  assign TRIS_C = dirc_r;
  assign TRIS_D = dird_r;
  assign TRIS_E = dire_r;
  assign PSP_MODE = pspmode_r;
  assign INT_CTRL = intctl_r;
  assign PERIPH_IRQ_EN_1 = ie1_r;
  assign PERIPH_IRQ_EN_2 = ie2_r;
  assign TMR2_PERIOD = period_r;
  assign SSP_ADDR = ssp_adr_r;
  assign TX_CTRL = txctl_r;
  assign BAUD_DIV = baud_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_ptr_write;
    WSTB && (ADDR == OFS_INDIRECT_POINTER);
  endsequence

  sequence s_ptr_mirror_read;
    RSTB && (ADDR == {1'b0, OFS_INDIRECT_POINTER[6:0]});
  endsequence

  sequence s_ind_ram_write;
    WSTB && is_ind && ea_ram;
  endsequence

  sequence s_ind_ram_read;
    RSTB && is_ind && $stable(ptr_r) && $stable(status_r[SF_IND_BANK]);
  endsequence

  chk_unmapped_read_zero: assert property (@(posedge CLOCK) disable iff (SRST) // [RQ1]
    RSTB && !map_hit(ADDR) |=> RDATA == RST_ZERO8)
    else $error("unmapped read not zero");

  chk_latch_upper_zero: assert property (@(posedge CLOCK) disable iff (SRST) // [RQ1]
    RSTB && map_hit(ADDR) && (canon(ADDR) == OFS_PC_HIGH_LATCH) |=> RDATA[7:5] == 3'b000)
    else $error("high latch upper bits not zero");

  chk_shared_mirror: assert property (@(posedge CLOCK) disable iff (SRST) // [RQ2]
    s_ptr_write ##1 s_ptr_mirror_read |=> RDATA == $past(WDATA, 2))
    else $error("pointer not shared across banks");

  chk_pc_high_load: assert property (@(posedge CLOCK) disable iff (SRST) // [RQ3]
    WSTB && !is_ind && map_hit(ADDR) && (canon(ADDR) == OFS_PC_LOW_BYTE)
    |=> PC_VALUE == {$past(latch_r), $past(WDATA)})
    else $error("pc not loaded from high latch");

  chk_other_reset_keeps: assert property (@(posedge CLOCK) // [RQ4]
    SRST && !pon |=> (ptr_r == $past(ptr_r)) && (pwr_r == $past(pwr_r)) && (BANK_SEL == 3'b000))
    else $error("other reset disturbed held state");

  chk_pon_values: assert property (@(posedge CLOCK) // [RQ4]
    SRST && pon |=> (status_r == RST_CORE_FLAGS_PON) && (ptr_r == RST_ZERO8))
    else $error("power-up values not loaded");

  chk_indirect_ram: assert property (@(posedge CLOCK) disable iff (SRST) // [RQ5]
    s_ind_ram_write ##1 s_ind_ram_read |=> RDATA == $past(WDATA, 2))
    else $error("indirect access did not reach data memory");

  chk_baud_clear: assert property (@(posedge CLOCK) // [RQ9]
    SRST |=> BAUD_DIV == RST_BAUD_DIVISOR)
    else $error("baud divisor not cleared");

  chk_reset_table: assert property (@(posedge CLOCK) // [RQ10]
    SRST |=> (OPTION_CFG == RST_PRESCALER_EDGE_CONFIG) && (TRIS_A == RST_DIR_PORT_A)
      && (TRIS_E == RST_DIR_PORT_E) && (TMR2_PERIOD == RST_TIMER2_PERIOD) && (PC_VALUE == RST_PC))
    else $error("reset table value missing");

  chk_overflow_set_wins: assert property (@(posedge CLOCK) disable iff (SRST)
    PSP_OVERFLOW |=> ibov_r)
    else $error("overflow flag lost");

  chk_rdata_one_cycle: assert property (@(posedge CLOCK) disable iff (SRST)
    !RSTB |=> RDATA == RST_ZERO8)
    else $error("read data held past its cycle");

endmodule : bsrm_bank1_map

// >>> sim/tb.sv
// self-checking bench for the bank 1 register map
`timescale 1ns/1ps
module tb;
  import bsrm_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic wstb = 1'b0;
  logic rstb = 1'b0;
  logic pc_step = 1'b0;
  logic psp_in = 1'b0;
  logic psp_out = 1'b0;
  logic psp_ov = 1'b0;
  logic tx_empty = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [5:0] ssp_st = 6'h00;
  bsrm_rst_cause_t cause = BSRM_RST_PON;
  logic [7:0] rdata, opt_cfg, dir_b, dir_c, dir_d, ssp_a, int_ctl, tmr2, tx_ctrl, baud, ie1, exp_v, v, r1;
  logic [12:0] pc;
  logic [5:0] dir_a;
  logic [2:0] bank, dir_e;
  logic psp_mode, ie2;
  logic [7:0] q[$];
  logic [7:0] vals [11];
  logic rd_pend = 1'b0;
  logic armed = 1'b0;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  // {address, reset value} after power-on
  logic [15:0] pon_tab [20] = '{16'h8000, 16'h81ff, 16'h8200, 16'h8318, 16'h8400, 16'h853f, 16'h86ff,
    16'h87ff, 16'h88ff, 16'h8907, 16'h8a00, 16'h8b00, 16'h8c00, 16'h8d00, 16'h8e01, 16'h92ff, 16'h9300,
    16'h9400, 16'h9802, 16'h9900};
  logic [7:0] unimp [12] = '{8'h8f, 8'h90, 8'h91, 8'h95, 8'h96, 8'h97, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9e, 8'h9f};
  // {address, implemented bits}
  logic [15:0] rw_tab [11] = '{16'h81ff, 16'h86ff, 16'h87ff, 16'h88ff, 16'h92ff, 16'h93ff, 16'h99ff,
    16'h8cff, 16'h853f, 16'h8a1f, 16'h8d01};

  bsrm_bank1_map DUT (.CLOCK(clock), .SRST(srst), .RST_CAUSE(cause), .ADDR(addr), .WDATA(wdata),
    .WSTB(wstb), .RSTB(rstb), .RDATA(rdata), .PC_STEP(pc_step), .PC_VALUE(pc), .BANK_SEL(bank),
    .PSP_IN_FULL(psp_in), .PSP_OUT_FULL(psp_out), .PSP_OVERFLOW(psp_ov), .SSP_STATUS(ssp_st),
    .TX_SHIFT_EMPTY(tx_empty), .OPTION_CFG(opt_cfg), .TRIS_A(dir_a), .TRIS_B(dir_b), .TRIS_C(dir_c),
    .TRIS_D(dir_d), .TRIS_E(dir_e), .PSP_MODE(psp_mode), .INT_CTRL(int_ctl), .PERIPH_IRQ_EN_1(ie1),
    .PERIPH_IRQ_EN_2(ie2), .TMR2_PERIOD(tmr2), .SSP_ADDR(ssp_a), .TX_CTRL(tx_ctrl), .BAUD_DIV(baud));

  always #20 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic fail_cmp(input string what, input logic [12:0] got, input logic [12:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : fail_cmp

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    fail_cmp("read data", {5'h00, got}, {5'h00, exp});
  endtask : cmp_rd

  task automatic cmp_out(input string what, input logic [12:0] got, input logic [12:0] exp);
    fail_cmp(what, got, exp);
  endtask : cmp_out

  // bus tasks leave the strobe up so transfers can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    rstb <= 1'b0;
    wstb <= 1'b1;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    wstb <= 1'b0;
    rstb <= 1'b1;
    q.push_back(e);
    @(posedge clock);
  endtask : rd

  task automatic idle;
    wstb <= 1'b0;
    rstb <= 1'b0;
    @(posedge clock);
  endtask : idle

  task automatic do_reset(input bsrm_rst_cause_t c);
    wstb <= 1'b0;
    rstb <= 1'b0;
    srst <= 1'b1;
    cause <= c;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
  endtask : do_reset

  // dirty the registers, reset with cause c, then read back
  task automatic rst_case(input bsrm_rst_cause_t c, input logic [7:0] f, input logic [7:0] p,
                          input logic [7:0] ic, input logic [7:0] pf);
    v = 8'($urandom);
    wr(8'h99, v | 8'h01);
    wr(8'h92, 8'h00);
    wr(8'h84, 8'h3c);
    wr(8'h83, 8'h05);
    wr(8'h8b, 8'hff);
    wr(8'h8e, 8'h03);
    idle();
    do_reset(c);
    rd(8'h83, f);
    rd(8'h84, p);
    rd(8'h8b, ic);
    rd(8'h8e, pf);
    rd(8'h99, 8'h00);
    rd(8'h92, 8'hff);
    rd(8'h8a, 8'h00);
    idle();
    cmp_out("int ctrl", {5'h00, int_ctl}, {5'h00, ic});
    cmp_out("baud", {5'h00, baud}, 13'h0000);
    cmp_out("pc", pc, 13'h0000);
  endtask : rst_case

  ////////////////////////////////////////////////////////////////////////////
  // read results appear in the cycle after the strobe; zero otherwise
  always @(posedge clock) rd_pend <= rstb && !srst;

  always @(negedge clock) begin
    if (armed && rd_pend) begin
      exp_v = (q.size() > 0) ? q.pop_front() : 8'hxx;
      cmp_rd(rdata, exp_v);
    end else if (armed) begin
      cmp_rd(rdata, 8'h00);
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(70545));
    do_reset(BSRM_RST_PON);
    armed <= 1'b1;
    foreach (pon_tab[k]) rd(pon_tab[k][15:8], pon_tab[k][7:0]);
    foreach (unimp[k]) wr(unimp[k], 8'hff);
    foreach (unimp[k]) rd(unimp[k], 8'h00);
    wr(8'h8e, 8'hff);
    rd(8'h8e, 8'h03);
    // random values through eleven plain registers, unimplemented bits masked
    foreach (rw_tab[k]) begin
      v = 8'($urandom);
      if (rw_tab[k][15:8] == 8'h8c) v = v & 8'hbf;
      vals[k] = v & rw_tab[k][7:0];
      wr(rw_tab[k][15:8], v);
      rd(rw_tab[k][15:8], vals[k]);
    end
    idle();
    cmp_out("option", {5'h00, opt_cfg}, {5'h00, vals[0]});
    cmp_out("dir b", {5'h00, dir_b}, {5'h00, vals[1]});
    cmp_out("period", {5'h00, tmr2}, {5'h00, vals[4]});
    cmp_out("baud", {5'h00, baud}, {5'h00, vals[6]});
    cmp_out("ie1", {5'h00, ie1}, {5'h00, vals[7]});
    cmp_out("dir a", {7'h00, dir_a}, {5'h00, vals[8]});
    cmp_out("dir c", {5'h00, dir_c}, {5'h00, vals[2]});
    cmp_out("dir d", {5'h00, dir_d}, {5'h00, vals[3]});
    cmp_out("ssp addr", {5'h00, ssp_a}, {5'h00, vals[5]});
    cmp_out("ie2", {12'h000, ie2}, {5'h00, vals[10]});
    // program counter: latch feeds the upper bits only on a low byte write
    wr(8'h0a, 8'hff);
    wr(8'h82, 8'hfe);
    idle();
    cmp_out("pc", pc, 13'h1ffe);
    rd(8'h02, 8'hfe);
    rd(8'h8a, 8'h1f);
    rstb <= 1'b0;
    pc_step <= 1'b1;
    repeat (3) @(posedge clock);
    pc_step <= 1'b0;
    wr(8'h8a, 8'h05);
    idle();
    cmp_out("pc", pc, 13'h0001);
    // core flags mirror and bank outputs; reserved upper bank bits kept clear
    wr(8'h03, 8'h25);
    rd(8'h83, 8'h3d);
    idle();
    cmp_out("bank", {10'h000, bank}, 13'h0001);
    wr(8'h83, 8'h05);
    // indirect port: map register, two memory cells, itself, a hole
    wr(8'h04, 8'h85);
    wr(8'h80, 8'h12);
    rd(8'h85, 8'h12);
    rd(8'h00, 8'h12);
    v = 8'($urandom);
    r1 = 8'($urandom);
    wr(8'h84, 8'ha0);
    wr(8'h00, v);
    wr(8'h84, 8'h20);
    wr(8'h80, ~v);
    rd(8'h80, ~v);
    wr(8'h84, 8'ha0);
    rd(8'h00, v);
    wr(8'h84, 8'h80);
    wr(8'h80, r1);
    rd(8'h80, 8'h00);
    wr(8'h84, 8'h8f);
    rd(8'h04, 8'h8f);
    rd(8'h80, 8'h00);
    // parallel port status and direction bits
    rstb <= 1'b0;
    psp_in <= 1'b1;
    psp_ov <= 1'b1;
    @(posedge clock);
    psp_ov <= 1'b0;
    rd(8'h89, 8'ha7);
    wr(8'h89, 8'h17);
    rd(8'h89, 8'h97);
    idle();
    cmp_out("psp mode", {12'h000, psp_mode}, 13'h0001);
    cmp_out("dir e", {10'h000, dir_e}, 13'h0007);
    psp_in <= 1'b0;
    psp_out <= 1'b1;
    rd(8'h89, 8'h57);
    // serial status and transmit control read-only bits
    ssp_st <= 6'($urandom);
    wr(8'h94, 8'hff);
    rd(8'h94, {2'b00, ssp_st});
    wr(8'h98, 8'hff);
    rd(8'h98, 8'hf7);
    idle();
    cmp_out("tx ctrl", {5'h00, tx_ctrl}, 13'h00f5);
    tx_empty <= 1'b0;
    rd(8'h98, 8'hf5);
    idle();
    tx_empty <= 1'b1;
    rst_case(BSRM_RST_PIN, 8'h1d, 8'h3c, 8'h01, 8'h03);
    rst_case(BSRM_RST_WDT, 8'h0d, 8'h3c, 8'h01, 8'h03);
    rst_case(BSRM_RST_BROWNOUT, 8'h18, 8'h00, 8'h00, 8'h02);
    repeat (2) @(posedge clock);
    report_and_stop();
  end
endmodule : tb
